// ---- design/flash_pin_pkg.sv ----
package flash_pin_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_NVCFG  = 8'h04;
  localparam logic [7:0] OFS_EVCFG  = 8'h08;
  localparam logic [7:0] OFS_TXDATA = 8'h0C;
  localparam logic [7:0] OFS_RXDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CYCLE  = 8'h18;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CFG_RESET     = 8'hFF;
  localparam logic [7:0]  TXDATA_RESET  = 8'h00;
  localparam logic [15:0] CYCLE_RESET   = 16'h0000;
  localparam int          CFG_PIN_FN_BIT = 4;
  localparam int          ST_RX_NEW_BIT  = 6;
  localparam int          ST_ABORT_BIT   = 5;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  OE_ALL_OFF    = 4'hF;

  // Lane width codes
  localparam logic [1:0] WIDTH_X1 = 2'h0;
  localparam logic [1:0] WIDTH_X2 = 2'h1;
  localparam logic [1:0] WIDTH_X4 = 2'h2;

  // Function carried by io_line3 besides data
  localparam logic [1:0] FN_NONE  = 2'h0;
  localparam logic [1:0] FN_RESET = 2'h1;
  localparam logic [1:0] FN_PAUSE = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pin_fn;
    logic       dedicated_rst;
    logic       respond;
    logic       dtr;
    logic       quad_proto;
    logic [1:0] width;
  } ctrl_s;

  typedef struct packed {
    logic [7:0] byte_count;
    logic       rst_active;
    logic       rx_new;
    logic       aborted;
    logic       armed;
    logic       busy;
    logic       paused;
    logic       active;
    logic       standby;
  } status_s;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef enum logic [1:0] {
    ST_UNARMED,
    ST_STANDBY,
    ST_ACTIVE,
    ST_PAUSED
  } state_e;

endpackage : flash_pin_pkg

// ---- design/pin_edge_detect.sv ----
`timescale 1ns/10ps
module pin_edge_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sclk,
  input  wire logic select_n,
  output logic      sclk_rise,
  output logic      sclk_fall,
  output logic      sel_fall
);

  // ----------------------------------------------------------------
  // Previous pin levels
  // ----------------------------------------------------------------
  logic sclk_q;
  logic select_n_q;

  // Idle levels at reset so no false edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q     <= 1'b0;
      select_n_q <= 1'b1;
    end else begin
      sclk_q     <= sclk;
      select_n_q <= select_n;
    end
  end

  // One-cycle edge pulses
  assign sclk_rise = sclk & ~sclk_q;
  assign sclk_fall = ~sclk & sclk_q;
  assign sel_fall  = ~select_n & select_n_q;

endmodule : pin_edge_detect

// ---- design/serial_flash_pin_control.sv ----
`timescale 1ns/10ps
module serial_flash_pin_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        select_n,
  input  wire logic        sclk,
  input  wire logic        reset_pin_n,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe_n
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Bits moved per edge for a lane width
  function automatic logic [3:0] lane_step(input logic [1:0] w);
    return (w == flash_pin_pkg::WIDTH_X4) ? 4'h4 :
           (w == flash_pin_pkg::WIDTH_X2) ? 4'h2 : 4'h1;
  endfunction : lane_step
  // Shift captured lanes into a byte, first bit ends up in the MSB
  function automatic logic [7:0] shift_lanes(input logic [1:0] w, input logic [7:0] sh,
                                             input logic [3:0] io);
    return (w == flash_pin_pkg::WIDTH_X4) ? {sh[3:0], io[3:0]} :
           (w == flash_pin_pkg::WIDTH_X2) ? {sh[5:0], io[1:0]} : {sh[6:0], io[0]};
  endfunction : shift_lanes

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  flash_pin_pkg::apb_req_s req;
  flash_pin_pkg::ctrl_s    ctrl;
  flash_pin_pkg::status_s  status;
  flash_pin_pkg::state_e   state;
  flash_pin_pkg::state_e   next_state;
  logic [7:0]  nvcfg, evcfg, tx_data, rx_data, rx_sh, tx_sh, byte_count, cap_byte;
  logic [15:0] cycle_cnt;
  logic [3:0]  bit_cnt, step, bit_sum, drv_bits, drv_mask, next_oe_n;
  logic [1:0]  eff_width;
  logic [31:0] rd_word;
  logic        drive_on, aborted, rx_new, busy, live, in_phase, byte_done;
  logic        sclk_rise, sclk_fall, sel_fall, cfg_fn_en, pin_reset_hit, pause_hit;
  logic        cap_edge, launch_edge, cap_fire, launch_fire;
  logic        acc, wr_fire, mapped, w1c_rx, w1c_ab;
  logic        hit_ctrl, hit_nv, hit_ev, hit_tx, hit_rx, hit_st, hit_cy;
  // Bus request bundle
  assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

  pin_edge_detect u_edges (
    .pclk      (pclk),
    .presetn   (presetn),
    .sclk      (sclk),
    .select_n  (select_n),
    .sclk_rise (sclk_rise),
    .sclk_fall (sclk_fall),
    .sel_fall  (sel_fall)
  );

  // ----------------------------------------------------------------
  // Pin function decode
  // ----------------------------------------------------------------
  // Both configuration copies must enable the io_line3 side function
  assign cfg_fn_en = nvcfg[flash_pin_pkg::CFG_PIN_FN_BIT]
                   & evcfg[flash_pin_pkg::CFG_PIN_FN_BIT];
  // Shared reset only while selected; dedicated pin listens whenever both configuration copies enable the function
  assign pin_reset_hit = cfg_fn_en & (ctrl.dedicated_rst ? ~reset_pin_n :
                         (ctrl.pin_fn == flash_pin_pkg::FN_RESET) & ~ctrl.quad_proto
                         & ~select_n & ~io_in[3]);
  // Pause is meaningless in quad or double rate, io_line3 is data there
  assign pause_hit = cfg_fn_en & (ctrl.pin_fn == flash_pin_pkg::FN_PAUSE)
                   & ~ctrl.quad_proto & ~ctrl.dtr & ~select_n & ~io_in[3];
  assign busy = (cycle_cnt != 16'h0000);

  // ----------------------------------------------------------------
  // Serial datapath decode
  // ----------------------------------------------------------------
  assign eff_width   = ctrl.quad_proto ? flash_pin_pkg::WIDTH_X4 : ctrl.width;
  assign step        = lane_step(eff_width);
  assign bit_sum     = bit_cnt + step;
  assign byte_done   = (bit_sum == flash_pin_pkg::BYTE_BITS);
  assign live        = (state == flash_pin_pkg::ST_ACTIVE) & ~select_n
                     & ~pause_hit & ~pin_reset_hit;
  assign in_phase    = ~(ctrl.respond & (byte_count != 8'h00));
  assign cap_edge    = ctrl.dtr ? (sclk_rise | sclk_fall) : sclk_rise;
  assign launch_edge = ctrl.dtr ? (sclk_rise | sclk_fall) : sclk_fall;
  assign cap_fire    = live & in_phase & cap_edge;
  assign launch_fire = live & ~in_phase & launch_edge;
  // Single line: io_line0 in only, io_line1 out only
  assign cap_byte = shift_lanes(eff_width, rx_sh, io_in);
  assign drv_bits = (eff_width == flash_pin_pkg::WIDTH_X4) ? tx_sh[7:4] :
                    (eff_width == flash_pin_pkg::WIDTH_X2) ? {2'b00, tx_sh[7:6]} :
                    {2'b00, tx_sh[7], 1'b0};
  assign drv_mask = (eff_width == flash_pin_pkg::WIDTH_X4) ? 4'h0 :
                    (eff_width == flash_pin_pkg::WIDTH_X2) ? 4'hC : 4'hD;
  // Float unless actively responding
  assign next_oe_n = (live & drive_on & ~in_phase) ? drv_mask : flash_pin_pkg::OE_ALL_OFF;

  // ----------------------------------------------------------------
  // Selection state
  // ----------------------------------------------------------------
  // Reset pin forces re-arming so a fresh select edge is needed
  always_comb begin
    next_state = state;
    unique case (state)
      flash_pin_pkg::ST_UNARMED: begin
        if (sel_fall) begin
          next_state = flash_pin_pkg::ST_ACTIVE;
        end
      end
      flash_pin_pkg::ST_STANDBY: begin
        if (!select_n) begin
          next_state = flash_pin_pkg::ST_ACTIVE;
        end
      end
      flash_pin_pkg::ST_ACTIVE: begin
        if (select_n) begin
          next_state = flash_pin_pkg::ST_STANDBY;
        end else if (pause_hit) begin
          next_state = flash_pin_pkg::ST_PAUSED;
        end
      end
      flash_pin_pkg::ST_PAUSED: begin
        if (select_n) begin
          next_state = flash_pin_pkg::ST_STANDBY;
        end else if (!pause_hit) begin
          next_state = flash_pin_pkg::ST_ACTIVE;
        end
      end
    endcase
    if (pin_reset_hit) begin
      next_state = flash_pin_pkg::ST_UNARMED;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= flash_pin_pkg::ST_UNARMED;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Shift and count
  // ----------------------------------------------------------------
  // Counters hold across a pause; deselect or reset drops the command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh      <= 8'h00;
      bit_cnt    <= 4'h0;
      byte_count <= 8'h00;
      rx_data    <= 8'h00;
    end else if (select_n || pin_reset_hit) begin
      rx_sh      <= 8'h00;
      bit_cnt    <= 4'h0;
      byte_count <= 8'h00;
    end else if (cap_fire) begin
      rx_sh      <= cap_byte;
      bit_cnt    <= byte_done ? 4'h0 : bit_sum;
      byte_count <= byte_done ? byte_count + 8'h01 : byte_count;
      rx_data    <= byte_done ? cap_byte : rx_data;
    end else if (launch_fire) begin
      bit_cnt    <= byte_done ? 4'h0 : bit_sum;
    end
  end

  // Output shifter reloads from tx_data at every byte boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh    <= 8'h00;
      io_out   <= 4'h0;
      drive_on <= 1'b0;
    end else if (select_n || pin_reset_hit) begin
      tx_sh    <= tx_data;
      drive_on <= 1'b0;
    end else if (launch_fire) begin
      io_out   <= drv_bits;
      tx_sh    <= byte_done ? tx_data : 8'((tx_sh << step));
      drive_on <= 1'b1;
    end
  end

  // Outputs float while deselected, paused or in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_oe_n <= flash_pin_pkg::OE_ALL_OFF;
    end else begin
      io_oe_n <= next_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  assign acc      = req.psel & req.penable;
  assign wr_fire  = acc & pready & req.pwrite;
  assign hit_ctrl = (req.paddr == flash_pin_pkg::OFS_CTRL);
  assign hit_nv   = (req.paddr == flash_pin_pkg::OFS_NVCFG);
  assign hit_ev   = (req.paddr == flash_pin_pkg::OFS_EVCFG);
  assign hit_tx   = (req.paddr == flash_pin_pkg::OFS_TXDATA);
  assign hit_rx   = (req.paddr == flash_pin_pkg::OFS_RXDATA);
  assign hit_st   = (req.paddr == flash_pin_pkg::OFS_STATUS);
  assign hit_cy   = (req.paddr == flash_pin_pkg::OFS_CYCLE);
  assign mapped   = hit_ctrl | hit_nv | hit_ev | hit_tx | hit_rx | hit_st | hit_cy;
  assign w1c_rx   = wr_fire & hit_st & req.pwdata[flash_pin_pkg::ST_RX_NEW_BIT];
  assign w1c_ab   = wr_fire & hit_st & req.pwdata[flash_pin_pkg::ST_ABORT_BIT];

  assign status = '{byte_count: byte_count,
                    rst_active: pin_reset_hit,
                    rx_new:     rx_new,
                    aborted:    aborted,
                    armed:      state != flash_pin_pkg::ST_UNARMED,
                    busy:       busy,
                    paused:     state == flash_pin_pkg::ST_PAUSED,
                    active:     state == flash_pin_pkg::ST_ACTIVE,
                    standby:    select_n & ~busy};

  assign rd_word = hit_ctrl ? {24'h000000, ctrl} :
                   hit_nv   ? {24'h000000, nvcfg} :
                   hit_ev   ? {24'h000000, evcfg} :
                   hit_tx   ? {24'h000000, tx_data} :
                   hit_rx   ? {24'h000000, rx_data} :
                   hit_st   ? {16'h0000, status} :
                   hit_cy   ? {16'h0000, cycle_cnt} : 32'h00000000;

  // Answer registered; unmapped addresses give pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata  <= (acc & ~pready & ~req.pwrite) ? rd_word : 32'h00000000;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= flash_pin_pkg::CTRL_RESET;
      nvcfg   <= flash_pin_pkg::CFG_RESET;
      evcfg   <= flash_pin_pkg::CFG_RESET;
      tx_data <= flash_pin_pkg::TXDATA_RESET;
    end else if (wr_fire) begin
      ctrl    <= hit_ctrl ? req.pwdata[7:0] : ctrl;
      nvcfg   <= hit_nv ? req.pwdata[7:0] : nvcfg;
      evcfg   <= hit_ev ? req.pwdata[7:0] : evcfg;
      tx_data <= hit_tx ? req.pwdata[7:0] : tx_data;
    end
  end

  // Internal cycle runs on regardless of select; reset aborts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_cnt <= flash_pin_pkg::CYCLE_RESET;
    end else if (pin_reset_hit) begin
      cycle_cnt <= flash_pin_pkg::CYCLE_RESET;
    end else if (wr_fire && hit_cy) begin
      cycle_cnt <= req.pwdata[15:0];
    end else if (busy) begin
      cycle_cnt <= cycle_cnt - 16'h0001;
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aborted <= 1'b0;
      rx_new  <= 1'b0;
    end else begin
      aborted <= (pin_reset_hit & busy) | (aborted & ~w1c_ab);
      rx_new  <= (cap_fire & byte_done) | (rx_new & ~w1c_rx);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // One clock domain, so clock and reset are given once
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_hiz_deselect;
    select_n |=> (io_oe_n == 4'hF);
  endproperty
  a_hiz_deselect: assert property (p_hiz_deselect) else $error("driven while deselected");
  property p_cycle_runs;
    (select_n && cycle_cnt > 16'h0001 && !pin_reset_hit && !wr_fire)
      |=> busy && !status.standby;
  endproperty
  a_cycle_runs: assert property (p_cycle_runs) else $error("internal cycle stopped early");
  property p_select_active;
    (state == flash_pin_pkg::ST_STANDBY && !select_n && !pin_reset_hit)
      |=> state == flash_pin_pkg::ST_ACTIVE;
  endproperty
  a_select_active: assert property (p_select_active) else $error("select did not activate");
  property p_need_edge;
    (state == flash_pin_pkg::ST_UNARMED && !sel_fall)
      |=> bit_cnt == 4'h0 && byte_count == 8'h00;
  endproperty
  a_need_edge: assert property (p_need_edge) else $error("capture before select edge");
  property p_str_capture;
    (!ctrl.dtr && sclk_fall && in_phase && !select_n && !pin_reset_hit)
      |=> $stable(bit_cnt);
  endproperty
  a_str_capture: assert property (p_str_capture) else $error("capture on falling edge");
  property p_launch_only;
    !launch_fire |=> $stable(io_out);
  endproperty
  a_launch_only: assert property (p_launch_only) else $error("io_out moved off launch");
  property p_reset_hiz;
    pin_reset_hit |=> (io_oe_n == 4'hF) && bit_cnt == 4'h0 && cycle_cnt == 16'h0000;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("pin reset not applied");
  property p_cfg_disable;
    !(nvcfg[4] && evcfg[4]) |-> !pin_reset_hit && !pause_hit;
  endproperty
  a_cfg_disable: assert property (p_cfg_disable) else $error("disabled pin function acted");
  property p_quad_no_reset;
    (ctrl.quad_proto && !ctrl.dedicated_rst) |-> !pin_reset_hit;
  endproperty
  a_quad_no_reset: assert property (p_quad_no_reset) else $error("shared reset in quad");
  property p_pause_hold;
    (pause_hit && !pin_reset_hit)
      |=> $stable(bit_cnt) && $stable(byte_count) && io_oe_n == 4'hF;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause lost state or drove");
  property p_pause_gated;
    (ctrl.quad_proto || ctrl.dtr) |-> !pause_hit;
  endproperty
  a_pause_gated: assert property (p_pause_gated) else $error("pause in quad or dtr");
  property p_deselect_drop;
    $rose(select_n) |-> ##1 (bit_cnt == 4'h0 && byte_count == 8'h00);
  endproperty
  a_deselect_drop: assert property (p_deselect_drop) else $error("partial command kept");
endmodule : serial_flash_pin_control

// ---- verification/host_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Host controller on select, clock and io lines
// ----------------------------------------
module host_model (
  input  wire logic       pclk,
  output logic            select_n,
  output logic            sclk,
  output logic      [3:0] io_in
);
  // Clock parked low between frames; io_line3 pulled up
  initial begin
    select_n = 1'b1;
    sclk     = 1'b0;
    io_in    = 4'hE;
  end
  // Select falls before any traffic, the first frame too
  task automatic open_frame();
    @(posedge pclk) select_n <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : open_frame
  // Msb first on io_line0, clock high two cycles then low three
  task automatic send_bits(input logic [7:0] d, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge pclk) io_in[0] <= d[i];
      repeat (2) @(posedge pclk);
      sclk <= 1'b1;
      repeat (2) @(posedge pclk);
      sclk <= 1'b0;
    end
  endtask : send_bits
  // Released lines show the inverse, not a stale level
  task automatic close_frame();
    @(posedge pclk) select_n <= 1'b1;
    io_in[2:0] <= ~io_in[2:0];
  endtask : close_frame
  // Pause request on the shared line; high again when off
  task automatic hold_line(input logic on);
    @(posedge pclk) io_in[3] <= ~on;
  endtask : hold_line
endmodule : host_model

// ---- verification/tb.sv ----
`timescale 1ns/10ps
module tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, select_n, sclk, err, reset_pin_n = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  io_in, io_out, io_oe_n;
  int          n_mismatch = 0, samples_checked = 0;
  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  always #12.5 pclk = ~pclk;
  serial_flash_pin_control dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .select_n, .sclk, .reset_pin_n, .io_in,
    .io_out, .io_oe_n);
  host_model host_u (.pclk, .select_n, .sclk, .io_in);
  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  // Request held until pready seen at an edge; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic pulse_rst();
    @(posedge pclk) reset_pin_n <= 1'b0;
    repeat (2) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask : pulse_rst
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(0, flash_pin_pkg::OFS_CTRL, 0);
    chk(rd, 32'h0, "ctrl");
    apb(0, flash_pin_pkg::OFS_EVCFG, 0);
    chk(rd, 32'hFF, "evcfg");
    apb(0, 8'h1C, 0);
    chk({31'h0, err}, 32'h1, "unmapped");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_rx();
    apb(1, flash_pin_pkg::OFS_CTRL, 32'h10);
    apb(1, flash_pin_pkg::OFS_TXDATA, 32'hA5);
    host_u.open_frame();
    apb(0, flash_pin_pkg::OFS_STATUS, 0);
    chk(rd[1], 1, "active");
    host_u.send_bits(8'h3C, 8);
    apb(0, flash_pin_pkg::OFS_RXDATA, 0);
    chk(rd, 32'h3C, "rx byte");
    chk(io_out[1], 1, "launch");
    chk(io_oe_n, 4'hD, "x1 lanes");
    host_u.close_frame();
    repeat (3) @(posedge pclk);
    chk(io_oe_n, 4'hF, "float");
    apb(0, flash_pin_pkg::OFS_STATUS, 0);
    chk(rd[0], 1, "standby");
    $display("t_rx done");
  endtask : t_rx
  // Paused bits dropped; second pass with pause disabled
  task automatic t_pause();
    apb(1, flash_pin_pkg::OFS_CTRL, 32'h90);
    host_u.open_frame();
    host_u.send_bits(8'hC3, 4);
    host_u.hold_line(1);
    host_u.send_bits(8'h00, 4);
    apb(0, flash_pin_pkg::OFS_STATUS, 0);
    chk(rd[2:1], 2'h2, "paused");
    host_u.hold_line(0);
    host_u.send_bits(8'h30, 4);
    apb(0, flash_pin_pkg::OFS_RXDATA, 0);
    chk(rd, 32'hC3, "resume");
    host_u.close_frame();
    apb(1, flash_pin_pkg::OFS_NVCFG, 32'hEF);
    host_u.open_frame();
    host_u.hold_line(1);
    host_u.send_bits(8'h5A, 8);
    host_u.hold_line(0);
    apb(0, flash_pin_pkg::OFS_RXDATA, 0);
    chk(rd, 32'h5A, "no pause");
    host_u.close_frame();
    apb(1, flash_pin_pkg::OFS_NVCFG, 32'hFF);
    $display("t_pause done");
  endtask : t_pause
  task automatic t_reset();
    apb(1, flash_pin_pkg::OFS_CTRL, 32'h30);
    host_u.open_frame();
    host_u.send_bits(8'h11, 8);
    pulse_rst();
    chk(io_oe_n, 4'hF, "rst float");
    host_u.close_frame();
    host_u.open_frame();
    host_u.close_frame();
    pulse_rst();
    apb(0, flash_pin_pkg::OFS_STATUS, 0);
    chk(rd[4], 0, "unarmed");
    apb(1, flash_pin_pkg::OFS_EVCFG, 32'hEF);
    host_u.open_frame();
    host_u.close_frame();
    pulse_rst();
    apb(0, flash_pin_pkg::OFS_STATUS, 0);
    chk(rd[4], 1, "rst off");
    $display("t_reset done");
  endtask : t_reset
  // Partial byte dropped; double rate and quad keep io_line3 as data
  task automatic t_modes();
    apb(1, flash_pin_pkg::OFS_EVCFG, 32'hFF);
    apb(1, flash_pin_pkg::OFS_CTRL, 32'h00);
    host_u.open_frame();
    host_u.send_bits(8'hFF, 3);
    host_u.close_frame();
    host_u.open_frame();
    host_u.send_bits(8'h96, 8);
    host_u.close_frame();
    apb(0, flash_pin_pkg::OFS_RXDATA, 0);
    chk(rd, 32'h96, "fresh byte");
    apb(1, flash_pin_pkg::OFS_CTRL, 32'h88);
    host_u.open_frame();
    host_u.hold_line(1);
    host_u.send_bits(8'hA0, 4);
    apb(0, flash_pin_pkg::OFS_RXDATA, 0);
    chk(rd, 32'hCC, "both edges");
    apb(0, flash_pin_pkg::OFS_STATUS, 0);
    chk(rd[2:1], 2'h1, "no pause in dtr");
    host_u.hold_line(0);
    host_u.close_frame();
    apb(1, flash_pin_pkg::OFS_CTRL, 32'h44);
    host_u.open_frame();
    host_u.hold_line(1);
    apb(0, flash_pin_pkg::OFS_STATUS, 0);
    chk({rd[7], rd[4]}, 2'h1, "quad line3 is data");
    host_u.hold_line(0);
    host_u.close_frame();
    $display("t_modes done");
  endtask : t_modes
  // Internal cycle outlives deselect; pin reset cuts it short
  task automatic t_cycle();
    apb(1, flash_pin_pkg::OFS_CTRL, 32'h20);
    apb(1, flash_pin_pkg::OFS_CYCLE, 32'h100);
    apb(0, flash_pin_pkg::OFS_STATUS, 0);
    chk({rd[3], rd[0]}, 2'h2, "busy not standby");
    pulse_rst();
    apb(0, flash_pin_pkg::OFS_STATUS, 0);
    chk(rd[5], 1, "aborted");
    apb(0, flash_pin_pkg::OFS_CYCLE, 0);
    chk(rd, 32'h0, "cycle cut");
    $display("t_cycle done");
  endtask : t_cycle
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rx();
    t_pause();
    t_reset();
    t_modes();
    t_cycle();
    close_out();
  end
  // Watchdog well past the expected few hundred cycles
  initial begin
    #500000;
    n_mismatch++;
    close_out();
  end
endmodule : tb
